// ---- bench/npnmce_dev_model.sv ----
// Behavioural nvSRAM on the NAND pins with open-drain ready/busy
`timescale 1ns/1ps
module npnmce_dev_model #(
    parameter int READ_ACCESS_DELAY = 20,
    parameter int T_SS = 50,
    parameter int T_RECALL = 300,
    parameter int T_STORE = 600
) (
    input wire logic ce_n,
    input wire logic cle,
    input wire logic ale,
    input wire logic we_n,
    input wire logic re_n,
    input wire logic [15:0] dq_in,
    output logic [15:0] dq_out,
    output logic rb_low
);
    logic [15:0] mem [int];
    logic [15:0] nv [int];
    logic [39:0] adr;
    logic [7:0] last;
    logic fail;
    int mode;
    int na;
    int ptr;
    initial begin
        rb_low = 0;
        dq_out = 16'h5a5a;
        mode = 0;
        fail = 0;
        na = 0;
    end
    // Parameter page tail: address cycle counts and timing mode support
    function automatic logic [7:0] pp_byte(input int i);
        case (i)
            101: return 8'h32;
            129: return 8'h00;
            130: return 8'h08;
            default: return 8'h00;
        endcase
    endfunction
    task automatic go_busy(input int t, input bit rec, input bit sto);
        mode = 0;
        rb_low = 1;
        #t;
        if (sto) nv = mem;
        if (rec) mem = nv;
        rb_low = 0;
    endtask
    always @(posedge we_n) begin
        if (!ce_n && cle && !ale && (!rb_low || dq_in[7:0] inside {8'h70, 8'hff})) begin
            case (dq_in[7:0])
                8'h70: mode = 1;
                8'h00, 8'h80: begin
                    mode = (dq_in[7:0] == 8'h00) ? 2 : 4;
                    na = 0;
                    fail = 0;
                end
                8'h30: begin
                    fail = (mode != 2 || na != 5);
                    mode = fail ? 0 : 3;
                end
                8'h10: mode = 0;
                8'h84: fail = 0;
                8'hec: begin
                    mode = 5;
                    na = 0;
                    adr = '0;
                end
                8'hff: if (!rb_low) fork go_busy(T_SS, 0, 0); join_none
                8'hfc: fork go_busy(T_SS + T_RECALL, 1, 0); join_none
                8'ha5: begin
                    fail = (last != 8'h84);
                    if (!fail) fork go_busy(T_STORE, 0, 1); join_none
                end
                default: fail = 1;
            endcase
            last = dq_in[7:0];
        end else if (!ce_n && ale && !cle && na < 5) begin
            adr[8*na +: 8] = dq_in[7:0];
            na++;
            ptr = int'(adr[20:0]);
        end else if (!ce_n && !cle && !ale && mode == 4 && na == 5 && !rb_low) begin
            mem[ptr] = dq_in;
            ptr = (ptr + 1) % (1 << 21);
        end
    end
    always @(negedge re_n) begin
        if (!ce_n && (mode == 1 || ((mode == 3 || mode == 5) && !rb_low))) begin
            #READ_ACCESS_DELAY;
            if (mode == 1) begin
                dq_out = {8'h00, 1'b1, !rb_low, 5'h00, fail};
            end else if (mode == 5) begin
                dq_out = {8'h00, pp_byte(ptr)};
                ptr++;
            end else begin
                dq_out = mem.exists(ptr) ? mem[ptr] : 16'h0;
                ptr = (ptr + 1) % (1 << 21);
            end
        end
    end
    // Released bus shows the inverse of the held value from 2 ns after re_n rises
    always @(posedge re_n) begin
        #2;
        dq_out = ~dq_out;
    end
endmodule

// ---- bench/tb_nand_port_nv_memory_command_engine.sv ----
// Self-checking bench: APB stimulus, device model, expected memory
`timescale 1ns/1ps
module tb_nand_port_nv_memory_command_engine;
    import npnmce_pkg::*;
    logic clock, reset, psel, penable, pwrite, pready, pslverr, saw_busy, er_v;
    logic ce_n, cle, ale, we_n, re_n, dq_oe, rb_low;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd_v, rng;
    logic [BUS_W-1:0] dq_o, dev_dq, dq_w;
    logic [15:0] exp_mem [int];
    logic [15:0] nv_mem [int];
    int err_total, n_tests;
    assign dq_w = dq_oe ? dq_o : dev_dq;
    npnmce_host #(.BUSY_ONSET(4)) dut (.CLOCK(clock), .RESET(reset), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .NAND_CE_N(ce_n), .NAND_CLE(cle), .NAND_ALE(ale),
        .NAND_WE_N(we_n), .NAND_RE_N(re_n), .NAND_DQ_I(dq_w), .NAND_DQ_O(dq_o),
        .NAND_DQ_OE(dq_oe), .NAND_READY_BUSY(!rb_low));
    npnmce_dev_model dev (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n),
        .dq_in(dq_w), .dq_out(dev_dq), .rb_low(rb_low));
    initial begin
        clock = 0;
        forever #2.5 clock = ~clock;
    end
    always @(posedge rb_low) saw_busy = 1;
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #400000;
        err_total++;
        end_sim();
    end
    // Xorshift step for random write data
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] r;
        r = v ^ (v << 13);
        r = r ^ (r >> 17);
        return r ^ (r << 5);
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1;
        // Answer taken at the rising edge where pready is sampled high
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd_v = prdata;
        er_v = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic poll();
        int n;
        n = 0;
        do begin
            apb(0, REG_STAT, 0);
            n++;
        end while (rd_v[STAT_BUSY] !== 1'b0 && n < 1000);
        if (n >= 1000) begin
            err_total++;
            end_sim();
        end
    endtask
    task automatic op(input logic [3:0] c);
        apb(1, REG_CTRL, {28'h0, c});
        chk({31'h0, er_v}, 0);
        poll();
    endtask
    task automatic burst(input logic [20:0] a, input int n, input bit wr);
        apb(1, REG_ADDR, {11'h0, a});
        op(wr ? 4'h7 : 4'h5);
        for (int i = 0; i < n; i++) begin
            if (wr) begin
                rng = xs(rng);
                exp_mem[(a + i) % (1 << 21)] = rng[15:0];
                apb(1, REG_WDATA, rng);
                op(4'h8);
            end else begin
                op(4'h6);
                apb(0, REG_RDATA, 0);
                chk(rd_v & 32'hffff, {16'h0, exp_mem[(a + i) % (1 << 21)]});
            end
        end
    endtask
    task automatic status_ok();
        op(4'h1);
        apb(0, REG_STAT, 0);
        chk(rd_v, 32'hc006);
    endtask
    initial begin
        reset = 1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {err_total, n_tests, saw_busy} = '0;
        rng = 33;
        repeat (6) @(posedge clock);
        reset <= 0;
        repeat (4) @(posedge clock);
        apb(0, REG_STAT, 0);
        chk(rd_v, 32'h2);
        apb(0, 8'h14, 0);
        chk({31'h0, er_v}, 1);
        apb(1, REG_CTRL, 32'ha);
        chk({31'h0, er_v}, 1);
        status_ok();
        $display("reset and status test done");
        burst(21'h1ffffe, 4, 1);
        op(4'h9);
        burst(21'h1ffffe, 4, 0);
        burst(21'h5, 1, 1);
        burst(21'h5, 1, 0);
        $display("burst test done");
        nv_mem = exp_mem;
        apb(1, REG_CTRL, 32'h4);
        apb(1, REG_CTRL, 32'h1);
        chk({31'h0, er_v}, 1);
        poll();
        chk({31'h0, saw_busy}, 1);
        burst(21'h5, 1, 1);
        op(4'h3);
        exp_mem = nv_mem;
        burst(21'h5, 1, 0);
        status_ok();
        op(4'h2);
        status_ok();
        $display("store recall reset test done");
        end_sim();
    end
endmodule

// ---- src/npnmce_host.sv ----
// Host controller for a NAND-port nvSRAM, with APB register slave
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module npnmce_host
    import npnmce_pkg::*;
#(
    parameter int BUSY_ONSET = BUSY_ONSET_CYC
) (
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic NAND_CE_N,
    output logic NAND_CLE,
    output logic NAND_ALE,
    output logic NAND_WE_N,
    output logic NAND_RE_N,
    input wire logic [BUS_W-1:0] NAND_DQ_I,
    output logic [BUS_W-1:0] NAND_DQ_O,
    output logic NAND_DQ_OE,
    input wire logic NAND_READY_BUSY
);
    typedef enum logic [4:0] {
        MS_IDLE = 5'b00001,
        MS_WAIT_RDY = 5'b00010,
        MS_SEND = 5'b00100,
        MS_WAIT_ONSET = 5'b01000,
        MS_WAIT_RB = 5'b10000
    } npnmce_ms_t;

    npnmce_seq_if sq ();

    npnmce_pin_seq u_seq (
        .clock(CLOCK),
        .reset(RESET),
        .sq(sq),
        .dq_i(NAND_DQ_I),
        .ce_n_q(NAND_CE_N),
        .cle_q(NAND_CLE),
        .ale_q(NAND_ALE),
        .we_n_q(NAND_WE_N),
        .re_n_q(NAND_RE_N),
        .dq_o_q(NAND_DQ_O),
        .dq_oe_q(NAND_DQ_OE)
    );

    npnmce_ms_t st_q, st_d;
    npnmce_op_t op_q, op_d;
    logic [2:0] step_q, step_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [BUS_W-1:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic [7:0] sbyte_q, sbyte_d;
    logic svalid_q, svalid_d;
    logic [15:0] wait_q, wait_d;
    logic req_q, req_d;
    npnmce_step_t cur_q, cur_d;
    logic rb_s1_q, rb_s2_q;
    logic [31:0] prdata_d;
    logic pready_d, pslverr_d;
    logic [7:0] sview;
    logic setup, acc, op_ok;

    // Bus cycles of each operation; address bytes low first, upper bits zero
    function automatic npnmce_step_t step_of(npnmce_op_t op, logic [2:0] i,
                                             logic [ADDR_W-1:0] a, logic [BUS_W-1:0] w);
        npnmce_step_t s;
        logic [7:0] ab;
        ab = (i == 3'd1) ? a[7:0] : (i == 3'd2) ? a[15:8] :
             (i == 3'd3) ? {3'h0, a[20:16]} : 8'h00;
        s = '{last: 1'b1, kind: CY_CMD, data: '0};
        case (op)
            OP_STATUS: begin
                s.last = (i == 3'd1);
                s.kind = (i == 3'd0) ? CY_CMD : CY_RDATA;
                s.data = {8'h00, NC_READ_STATUS};
            end
            OP_RESET: s.data = {8'h00, NC_RESET};
            OP_RECALL: s.data = {8'h00, NC_RECALL};
            OP_STORE: begin
                s.last = (i == 3'd1);
                s.data = {8'h00, (i == 3'd0) ? NC_STORE_1 : NC_STORE_2};
            end
            OP_READ_SETUP: begin
                s.last = (i == 3'd6);
                s.kind = (i == 3'd0 || i == 3'd6) ? CY_CMD : CY_ADDR;
                s.data = {8'h00, (i == 3'd0) ? NC_READ_1 : (i == 3'd6) ? NC_READ_2 : ab};
            end
            OP_READ_WORD: s.kind = CY_RDATA;
            OP_WRITE_SETUP: begin
                s.last = (i == 3'd5);
                s.kind = (i == 3'd0) ? CY_CMD : CY_ADDR;
                s.data = {8'h00, (i == 3'd0) ? NC_WRITE_1 : ab};
            end
            OP_WRITE_WORD: begin
                s.kind = CY_WDATA;
                s.data = w;
            end
            OP_WRITE_END: s.data = {8'h00, NC_WRITE_END};
            default: s.last = 1'b1;
        endcase
        return s;
    endfunction

    function automatic logic op_valid(logic [3:0] c);
        return c >= 4'(OP_STATUS) && c <= 4'(OP_WRITE_END);
    endfunction

    // Fail and spare bits are only meaningful while ready reads one
    assign sview = {sbyte_q[SB_WP], sbyte_q[SB_RDY], 5'h00,
                    sbyte_q[SB_RDY] & sbyte_q[SB_FAIL]};
    assign setup = PSEL && !PENABLE;
    assign acc = PSEL && PENABLE && PREADY;
    assign op_ok = op_valid(PWDATA[3:0]) && st_q == MS_IDLE;
    assign sq.req = req_q;
    assign sq.kind = cur_q.kind;
    assign sq.data = cur_q.data;

    always_comb begin
        prdata_d = PRDATA;
        pready_d = setup;
        pslverr_d = 1'b0;
        if (setup) begin
            prdata_d = 32'h0000_0000;
            case (PADDR)
                REG_CTRL: begin
                    prdata_d[3:0] = op_q;
                    pslverr_d = PWRITE && !op_ok;
                end
                REG_ADDR: prdata_d[ADDR_W-1:0] = addr_q;
                REG_WDATA: prdata_d[BUS_W-1:0] = wdata_q;
                REG_RDATA: prdata_d[BUS_W-1:0] = rdata_q;
                REG_STAT: begin
                    prdata_d[STAT_BUSY] = (st_q != MS_IDLE);
                    prdata_d[STAT_RB] = rb_s2_q;
                    prdata_d[STAT_VALID] = svalid_q;
                    prdata_d[STAT_BYTE_LSB +: 8] = sview;
                end
                default: pslverr_d = 1'b1;
            endcase
        end
    end

    always_comb begin
        st_d = st_q;
        op_d = op_q;
        step_d = step_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        sbyte_d = sbyte_q;
        svalid_d = svalid_q;
        wait_d = wait_q;
        req_d = req_q;
        cur_d = cur_q;
        if (acc && PWRITE && !PSLVERR) begin
            case (PADDR)
                REG_ADDR: addr_d = PWDATA[ADDR_W-1:0];
                REG_WDATA: wdata_d = PWDATA[BUS_W-1:0];
                default: ;
            endcase
        end
        case (st_q)
            MS_IDLE: begin
                if (acc && PWRITE && !PSLVERR && PADDR == REG_CTRL) begin
                    op_d = npnmce_op_t'(PWDATA[3:0]);
                    step_d = 3'h0;
                    if (PWDATA[3:0] == 4'(OP_STATUS)) begin
                        svalid_d = 1'b0;
                        st_d = MS_SEND;
                    end else begin
                        st_d = MS_WAIT_RDY;
                    end
                end
            end
            MS_WAIT_RDY: begin
                if (rb_s2_q) begin
                    st_d = MS_SEND;
                end
            end
            MS_SEND: begin
                if (!req_q) begin
                    cur_d = step_of(op_q, step_q, addr_q, wdata_q);
                    req_d = 1'b1;
                end else if (sq.done) begin
                    req_d = 1'b0;
                    step_d = step_q + 3'h1;
                    if (cur_q.kind == CY_RDATA) begin
                        rdata_d = sq.rdata;
                        if (op_q == OP_STATUS) begin
                            sbyte_d = sq.rdata[7:0];
                            svalid_d = 1'b1;
                        end
                    end
                    if (cur_q.last) begin
                        wait_d = 16'(BUSY_ONSET);
                        case (op_q)
                            OP_RESET, OP_RECALL, OP_STORE, OP_READ_SETUP:
                                st_d = MS_WAIT_ONSET;
                            default: st_d = MS_IDLE;
                        endcase
                    end
                end
            end
            MS_WAIT_ONSET: begin
                wait_d = wait_q - 16'h1;
                if (wait_q == 16'h1) begin
                    st_d = MS_WAIT_RB;
                end
            end
            MS_WAIT_RB: begin
                if (rb_s2_q) begin
                    st_d = MS_IDLE;
                end
            end
            default: st_d = MS_IDLE;
        endcase
    end

    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            PRDATA <= 32'h0000_0000;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            st_q <= MS_IDLE;
            op_q <= OP_NONE;
            step_q <= 3'h0;
            addr_q <= '0;
            wdata_q <= '0;
            rdata_q <= '0;
            sbyte_q <= 8'h00;
            svalid_q <= 1'b0;
            wait_q <= 16'h0;
            req_q <= 1'b0;
            cur_q <= '0;
            rb_s1_q <= 1'b0;
            rb_s2_q <= 1'b0;
        end else begin
            PRDATA <= prdata_d;
            PREADY <= pready_d;
            PSLVERR <= pslverr_d;
            st_q <= st_d;
            op_q <= op_d;
            step_q <= step_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            sbyte_q <= sbyte_d;
            svalid_q <= svalid_d;
            wait_q <= wait_d;
            req_q <= req_d;
            cur_q <= cur_d;
            rb_s1_q <= NAND_READY_BUSY;
            rb_s2_q <= rb_s1_q;
        end
    end

    ready_gate_a: assert property (
        @(posedge CLOCK) disable iff (RESET)
        (st_q == MS_WAIT_RDY && st_d == MS_SEND) |-> rb_s2_q ##1 (op_q != OP_STATUS))
        else $error("command issued while device busy");
    status_mask_a: assert property (
        @(posedge CLOCK) disable iff (RESET)
        (PREADY && PADDR == REG_STAT && !PRDATA[STAT_BYTE_LSB + SB_RDY])
        |-> PRDATA[STAT_BYTE_LSB +: 6] == 6'h00)
        else $error("status bits shown while device busy");
    busy_wait_a: assert property (
        @(posedge CLOCK) disable iff (RESET)
        $rose(st_q == MS_WAIT_ONSET) |-> (st_q == MS_WAIT_ONSET)[*3])
        else $error("busy onset wait cut short");
endmodule

// ---- src/npnmce_pin_seq.sv ----
// Pin sequencer: one command, address or data cycle on the NAND pins
`timescale 1ns/1ps
module npnmce_pin_seq
    import npnmce_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    npnmce_seq_if.seq sq,
    input wire logic [BUS_W-1:0] dq_i,
    output logic ce_n_q,
    output logic cle_q,
    output logic ale_q,
    output logic we_n_q,
    output logic re_n_q,
    output logic [BUS_W-1:0] dq_o_q,
    output logic dq_oe_q
);
    typedef enum logic [2:0] {
        PS_IDLE = 3'b001,
        PS_LOW = 3'b010,
        PS_HIGH = 3'b100
    } npnmce_ps_t;
    npnmce_ps_t st_q, st_d;
    logic [3:0] cnt_q, cnt_d;
    logic [3:0] div_q, div_d;
    logic tick_q, tick_d;
    logic [BUS_W-1:0] dq_s1_q, dq_s2_q;
    logic ce_n_d, cle_d, ale_d, we_n_d, re_n_d, dq_oe_d, done_q, done_d;
    logic [BUS_W-1:0] dq_o_d, rdata_q, rdata_d;
    logic rd_q, rd_d;

    assign sq.done = done_q;
    assign sq.rdata = rdata_q;

    always_comb begin
        div_d = div_q + 4'h1;
        tick_d = 1'b0;
        if (div_q == 4'(TICK_CYC - 1)) begin
            div_d = 4'h0;
            tick_d = 1'b1;
        end
        st_d = st_q;
        cnt_d = cnt_q;
        ce_n_d = ce_n_q;
        cle_d = cle_q;
        ale_d = ale_q;
        we_n_d = we_n_q;
        re_n_d = re_n_q;
        dq_o_d = dq_o_q;
        dq_oe_d = dq_oe_q;
        rdata_d = rdata_q;
        rd_d = rd_q;
        done_d = 1'b0;
        case (st_q)
            PS_IDLE: begin
                if (sq.req && !done_q) begin
                    ce_n_d = 1'b0;
                    cle_d = (sq.kind == CY_CMD);
                    ale_d = (sq.kind == CY_ADDR);
                    rd_d = (sq.kind == CY_RDATA);
                    dq_oe_d = (sq.kind != CY_RDATA);
                    // Commands and addresses only on the low byte
                    dq_o_d = (sq.kind == CY_WDATA) ? sq.data : {8'h00, sq.data[7:0]};
                    we_n_d = (sq.kind == CY_RDATA);
                    re_n_d = (sq.kind != CY_RDATA);
                    cnt_d = (sq.kind == CY_RDATA) ? 4'(RE_LOW_TICKS) : 4'(WE_LOW_TICKS);
                    st_d = PS_LOW;
                end
            end
            PS_LOW: begin
                if (tick_q) begin
                    cnt_d = cnt_q - 4'h1;
                    if (cnt_q == 4'h1) begin
                        if (rd_q) begin
                            rdata_d = dq_s2_q;
                        end
                        we_n_d = 1'b1;
                        re_n_d = 1'b1;
                        cnt_d = 4'(WE_HIGH_TICKS);
                        st_d = PS_HIGH;
                    end
                end
            end
            PS_HIGH: begin
                if (tick_q) begin
                    cnt_d = cnt_q - 4'h1;
                    if (cnt_q == 4'h1) begin
                        ce_n_d = 1'b1;
                        cle_d = 1'b0;
                        ale_d = 1'b0;
                        dq_oe_d = 1'b0;
                        done_d = 1'b1;
                        st_d = PS_IDLE;
                    end
                end
            end
            default: st_d = PS_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            st_q <= PS_IDLE;
            cnt_q <= 4'h0;
            div_q <= 4'h0;
            tick_q <= 1'b0;
            dq_s1_q <= '0;
            dq_s2_q <= '0;
            ce_n_q <= 1'b1;
            cle_q <= 1'b0;
            ale_q <= 1'b0;
            we_n_q <= 1'b1;
            re_n_q <= 1'b1;
            dq_o_q <= '0;
            dq_oe_q <= 1'b0;
            rdata_q <= '0;
            rd_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            div_q <= div_d;
            tick_q <= tick_d;
            dq_s1_q <= dq_i;
            dq_s2_q <= dq_s1_q;
            ce_n_q <= ce_n_d;
            cle_q <= cle_d;
            ale_q <= ale_d;
            we_n_q <= we_n_d;
            re_n_q <= re_n_d;
            dq_o_q <= dq_o_d;
            dq_oe_q <= dq_oe_d;
            rdata_q <= rdata_d;
            rd_q <= rd_d;
            done_q <= done_d;
        end
    end

    cycle_class_a: assert property (
        @(posedge clock) disable iff (reset) $rose(we_n_q) |-> !(cle_q && ale_q))
        else $error("command and address latch both high at write strobe");
    cmd_low_byte_a: assert property (
        @(posedge clock) disable iff (reset) (cle_q || ale_q) |-> dq_o_q[15:8] == 8'h00)
        else $error("upper data lines not zero in command or address cycle");
    read_release_a: assert property (
        @(posedge clock) disable iff (reset) !re_n_q |-> (!dq_oe_q && we_n_q && !ce_n_q))
        else $error("host drives data or write strobe during read strobe");
    write_pulse_a: assert property (
        @(posedge clock) disable iff (reset) $fell(we_n_q) |-> !we_n_q[*3] ##1 dq_oe_q)
        else $error("write strobe low too short or data released early");
endmodule

// ---- src/npnmce_pkg.sv ----
// Constants, types and register map of the NAND-port nvSRAM host controller
package npnmce_pkg;
    localparam int BUS_W = 16;
    // Clock period in ps and bus timing in ns, with cycle and tick counts derived
    localparam int CLK_PERIOD_PS = 5000;
    localparam int T_TICK_NS = 10;
    localparam int TICK_CYC = (T_TICK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int T_WE_LOW_NS = 15;
    localparam int T_WE_HIGH_NS = 10;
    localparam int T_READ_ACCESS_DELAY_NS = 30;
    localparam int T_BUSY_ONSET_NS = 100;
    localparam int WE_LOW_TICKS = (T_WE_LOW_NS + T_TICK_NS - 1) / T_TICK_NS;
    localparam int WE_HIGH_TICKS = (T_WE_HIGH_NS + T_TICK_NS - 1) / T_TICK_NS;
    // One extra tick covers the two-flop data synchroniser
    localparam int RE_LOW_TICKS = (T_READ_ACCESS_DELAY_NS + T_TICK_NS - 1) / T_TICK_NS + 1;
    localparam int BUSY_ONSET_CYC = (T_BUSY_ONSET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Device command codes
    localparam logic [7:0] NC_READ_STATUS = 8'h70;
    localparam logic [7:0] NC_READ_1 = 8'h00;
    localparam logic [7:0] NC_READ_2 = 8'h30;
    localparam logic [7:0] NC_WRITE_1 = 8'h80;
    localparam logic [7:0] NC_WRITE_END = 8'h10;
    localparam logic [7:0] NC_RESET = 8'hff;
    localparam logic [7:0] NC_RECALL = 8'hfc;
    localparam logic [7:0] NC_STORE_1 = 8'h84;
    localparam logic [7:0] NC_STORE_2 = 8'ha5;
    // Device status byte fields
    localparam int SB_WP = 7;
    localparam int SB_RDY = 6;
    localparam int SB_FAIL = 0;
    // Device parameter page fields
    localparam int PP_ADDR_CYCLES_BYTE = 101;
    localparam logic [7:0] PP_ADDR_CYCLES_VAL = 8'h32;
    localparam int PP_TIMING_MODE_BYTE = 129;
    localparam logic [7:0] PP_MODE3_VAL = 8'h08;
    localparam logic [7:0] PP_MODE2_VAL = 8'h04;
    // Host register map (APB byte offsets)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_RDATA = 8'h0c;
    localparam logic [7:0] REG_STAT = 8'h10;
    localparam int ADDR_W = 21;
    localparam int STAT_BUSY = 0;
    localparam int STAT_RB = 1;
    localparam int STAT_VALID = 2;
    localparam int STAT_BYTE_LSB = 8;
    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_STATUS = 4'h1,
        OP_RESET = 4'h2,
        OP_RECALL = 4'h3,
        OP_STORE = 4'h4,
        OP_READ_SETUP = 4'h5,
        OP_READ_WORD = 4'h6,
        OP_WRITE_SETUP = 4'h7,
        OP_WRITE_WORD = 4'h8,
        OP_WRITE_END = 4'h9
    } npnmce_op_t;
    typedef enum logic [1:0] {
        CY_CMD = 2'h0,
        CY_ADDR = 2'h1,
        CY_WDATA = 2'h2,
        CY_RDATA = 2'h3
    } npnmce_cycle_t;
    typedef struct packed {
        logic last;
        npnmce_cycle_t kind;
        logic [BUS_W-1:0] data;
    } npnmce_step_t;
endpackage

// ---- src/npnmce_seq_if.sv ----
// Link between the command engine and the pin sequencer
`timescale 1ns/1ps
interface npnmce_seq_if;
    import npnmce_pkg::*;
    logic req;
    npnmce_cycle_t kind;
    logic [BUS_W-1:0] data;
    logic done;
    logic [BUS_W-1:0] rdata;
    modport ctl (output req, output kind, output data, input done, input rdata);
    modport seq (input req, input kind, input data, output done, output rdata);
endinterface
